// [rtl/fault_record_pkg.sv]
// Constants and carrier types for the fault log record formatter.
// Assumes one system clock and a same-clock ADC sequencer and bus engine.
package fault_record_pkg;

  // ****************************************
  // Record layout
  // ****************************************
  localparam logic [7:0] REC_LEN = 8'h93;
  localparam logic [7:0] REC_LEN_EMPTY = 8'h00;
  localparam logic [7:0] TIME_FIRST = 8'h05;
  localparam logic [7:0] TIME_LAST = 8'h0A;
  localparam logic [7:0] IOUT1_PEAK_HI = 8'h11;
  localparam logic [7:0] VIN_PEAK_HI = 8'h13;
  localparam logic [7:0] TEMP0_HI = 8'h15;
  localparam logic [7:0] TEMP1_HI = 8'h17;
  localparam logic [7:0] TEMP_DIE_HI = 8'h19;
  localparam logic [7:0] PAGE_BASE = 8'h1B;
  localparam logic [7:0] PAGE_BYTES = 8'h14;
  localparam int PAGE_COUNT = 6;
  localparam int PAGE_BITS = 160;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ****************************************
  // Conversion sequence and timing
  // ****************************************
  localparam logic [4:0] LAST_STEP = 5'h19;
  localparam int CLK_HZ = 25000000;
  localparam int TICK_US = 200;
  localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  localparam int TIME_BITS = 48;
  localparam logic [15:0] PEAK_CLEAR_VALUE = 16'h0000;

  // ****************************************
  // Carriers
  // ****************************************
  // Fields in record order: first declared is first byte on the bus
  typedef struct packed {
    logic [15:0] vout0;
    logic [15:0] vout1;
    logic [15:0] iout0;
    logic [15:0] iout1;
    logic [15:0] vin;
    logic [15:0] iin;
    logic [7:0] status_vout0;
    logic [7:0] status_vout1;
    logic [15:0] status_word0;
    logic [15:0] status_word1;
    logic [7:0] status_mfr0;
    logic [7:0] status_mfr1;
  } event_page_s;

  typedef struct packed {
    logic [15:0] temp0;
    logic [15:0] temp1;
    logic [15:0] temp_die;
  } temps_s;

  typedef enum logic [1:0] {ST_RUN, ST_PENDING, ST_FROZEN} log_state_e;

endpackage

// [rtl/event_page_ring.sv]
// Ring of cyclical event pages, read back by age (0 is newest).
// Assumes writes come from the formatter once per completed ADC pass.
module event_page_ring #(
  parameter int DEPTH = fault_record_pkg::PAGE_COUNT
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_wr,
  input wire fault_record_pkg::event_page_s i_page,
  input wire logic [2:0] i_age,
  output fault_record_pkg::event_page_s o_page
);

  fault_record_pkg::event_page_s pages_q [DEPTH];
  logic [2:0] wr_ptr_q;
  logic [2:0] wr_ptr_d;
  logic [2:0] rd_slot;
  int slot_calc;

  // ****************************************
  // Slot arithmetic
  // ****************************************
  assign wr_ptr_d = (int'(wr_ptr_q) == DEPTH - 1) ? 3'h0 : wr_ptr_q + 3'h1;
  assign slot_calc = (int'(wr_ptr_q) + 2 * DEPTH - 1 - int'(i_age)) % DEPTH;
  assign rd_slot = 3'(slot_calc);
  assign o_page = pages_q[rd_slot];

  // Write lands on the oldest slot, then the pointer moves on
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      wr_ptr_q <= 3'h0;
    end else if (i_wr) begin
      wr_ptr_q <= wr_ptr_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        pages_q[i] <= '0;
      end
    end else if (i_wr) begin
      pages_q[wr_ptr_q] <= i_page;
    end
  end

endmodule

// [rtl/fault_log_record_formatter.sv]
// Fault log record formatter: peaks, temperatures, time stamp and event pages.
// Assumes the ADC sequencer, bus engine and non-volatile store share i_clk_sys.
module fault_log_record_formatter #(
  parameter int TICK_CYCLES = fault_record_pkg::TICK_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_conv_valid,
  input wire logic [4:0] i_conv_step,
  input wire fault_record_pkg::event_page_s i_conv_page,
  input wire fault_record_pkg::temps_s i_conv_temps,
  input wire logic i_fault,
  input wire logic i_peak_clear_command,
  input wire logic i_rd_req,
  input wire logic [7:0] i_rd_addr,
  output logic o_rd_ack,
  output logic [7:0] o_rd_data,
  output logic [7:0] o_rd_len,
  output logic o_frozen,
  output logic o_commit,
  output logic [15:0] o_peak_output_current,
  output logic [15:0] o_peak_input_voltage,
  output logic [47:0] o_shared_time_counter
);

  // ****************************************
  // Declarations
  // ****************************************
  fault_record_pkg::log_state_e state_q;
  fault_record_pkg::log_state_e state_d;
  fault_record_pkg::event_page_s ring_page;
  fault_record_pkg::temps_s temps_q;
  logic [31:0] tick_q;
  logic [47:0] time_q;
  logic [47:0] time_cap_q;
  logic [15:0] peak_iout_q;
  logic [15:0] peak_vin_q;
  logic [15:0] peak_iout_cap_q;
  logic [15:0] peak_vin_cap_q;
  logic pass_end;
  logic ring_wr;
  logic freeze;
  logic tick;
  logic iout_higher;
  logic vin_higher;
  logic hdr_sel;
  logic [7:0] hdr_byte;
  logic [7:0] page_off;
  logic [7:0] page_idx;
  logic [7:0] page_byte_pos;
  logic [7:0] rd_byte;
  logic [159:0] page_flat;
  logic [7:0] time_idx;
  logic [2:0] age;

  // Two's-complement signed compare of two linear_exp_format values
  function automatic logic exp_fmt_gt(input logic [15:0] a, input logic [15:0] b);
    logic signed [63:0] va;
    logic signed [63:0] vb;
    va = 64'(signed'(a[10:0])) <<< (5'(a[15:11]) + 5'h10);
    vb = 64'(signed'(b[10:0])) <<< (5'(b[15:11]) + 5'h10);
    exp_fmt_gt = va > vb;
  endfunction

  // ****************************************
  // Pass tracking and freeze control
  // ****************************************
  assign pass_end = i_conv_valid && (i_conv_step == fault_record_pkg::LAST_STEP);
  assign ring_wr = pass_end && (state_q != fault_record_pkg::ST_FROZEN);
  assign freeze = pass_end && (state_q == fault_record_pkg::ST_PENDING);

  always_comb begin
    state_d = state_q;
    case (state_q)
      fault_record_pkg::ST_RUN: begin
        if (i_fault) begin
          state_d = pass_end ? fault_record_pkg::ST_FROZEN : fault_record_pkg::ST_PENDING;
        end
      end
      fault_record_pkg::ST_PENDING: begin
        if (pass_end) begin
          state_d = fault_record_pkg::ST_FROZEN;
        end
      end
      fault_record_pkg::ST_FROZEN: state_d = fault_record_pkg::ST_FROZEN;
      default: state_d = fault_record_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state_q <= fault_record_pkg::ST_RUN;
      o_frozen <= 1'b0;
      o_commit <= 1'b0;
    end else begin
      state_q <= state_d;
      o_frozen <= (state_d == fault_record_pkg::ST_FROZEN);
      o_commit <= freeze || (i_fault && pass_end && state_q == fault_record_pkg::ST_RUN);
    end
  end

  event_page_ring #(
    .DEPTH(fault_record_pkg::PAGE_COUNT)
  ) u_ring (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_wr(ring_wr),
    .i_page(i_conv_page),
    .i_age(age),
    .o_page(ring_page)
  );

  // Temperatures of the last pass completed before the record froze
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      temps_q <= '0;
    end else if (ring_wr) begin
      temps_q <= i_conv_temps;
    end
  end

  // ****************************************
  // Shared time counter
  // ****************************************
  assign tick = (tick_q == 32'(TICK_CYCLES - 1));

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      tick_q <= '0;
      time_q <= '0;
      time_cap_q <= '0;
    end else begin
      tick_q <= tick ? '0 : tick_q + 32'h1;
      if (tick) begin
        time_q <= time_q + 48'h1;
      end
      if (i_fault && state_q == fault_record_pkg::ST_RUN) begin
        time_cap_q <= time_q;
      end
    end
  end

  // ****************************************
  // Peak tracking
  // ****************************************
  assign iout_higher = exp_fmt_gt(i_conv_page.iout1, peak_iout_q);
  assign vin_higher = exp_fmt_gt(i_conv_page.vin, peak_vin_q);

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || i_peak_clear_command) begin
      peak_iout_q <= fault_record_pkg::PEAK_CLEAR_VALUE;
      peak_vin_q <= fault_record_pkg::PEAK_CLEAR_VALUE;
    end else if (i_conv_valid) begin
      if (iout_higher) begin
        peak_iout_q <= i_conv_page.iout1;
      end
      if (vin_higher) begin
        peak_vin_q <= i_conv_page.vin;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      peak_iout_cap_q <= '0;
      peak_vin_cap_q <= '0;
      o_peak_output_current <= '0;
      o_peak_input_voltage <= '0;
      o_shared_time_counter <= '0;
    end else begin
      if (state_q != fault_record_pkg::ST_FROZEN) begin
        peak_iout_cap_q <= peak_iout_q;
        peak_vin_cap_q <= peak_vin_q;
      end
      o_peak_output_current <= peak_iout_q;
      o_peak_input_voltage <= peak_vin_q;
      o_shared_time_counter <= time_q;
    end
  end

  // ****************************************
  // Record byte selection
  // ****************************************
  assign time_idx = i_rd_addr - fault_record_pkg::TIME_FIRST;
  assign hdr_sel = i_rd_addr < fault_record_pkg::PAGE_BASE;
  assign page_off = i_rd_addr - fault_record_pkg::PAGE_BASE;
  assign page_idx = page_off / fault_record_pkg::PAGE_BYTES;
  assign page_byte_pos = page_off % fault_record_pkg::PAGE_BYTES;
  assign age = 3'(page_idx);
  assign page_flat = ring_page;

  always_comb begin
    hdr_byte = fault_record_pkg::BYTE_ZERO;
    if (i_rd_addr >= fault_record_pkg::TIME_FIRST && i_rd_addr <= fault_record_pkg::TIME_LAST) begin
      hdr_byte = time_cap_q[time_idx[2:0] * 8 +: 8];
    end else if (i_rd_addr == fault_record_pkg::IOUT1_PEAK_HI) begin
      hdr_byte = peak_iout_cap_q[15:8];
    end else if (i_rd_addr == fault_record_pkg::IOUT1_PEAK_HI + 8'h1) begin
      hdr_byte = peak_iout_cap_q[7:0];
    end else if (i_rd_addr == fault_record_pkg::VIN_PEAK_HI) begin
      hdr_byte = peak_vin_cap_q[15:8];
    end else if (i_rd_addr == fault_record_pkg::VIN_PEAK_HI + 8'h1) begin
      hdr_byte = peak_vin_cap_q[7:0];
    end else if (i_rd_addr == fault_record_pkg::TEMP0_HI) begin
      hdr_byte = temps_q.temp0[15:8];
    end else if (i_rd_addr == fault_record_pkg::TEMP0_HI + 8'h1) begin
      hdr_byte = temps_q.temp0[7:0];
    end else if (i_rd_addr == fault_record_pkg::TEMP1_HI) begin
      hdr_byte = temps_q.temp1[15:8];
    end else if (i_rd_addr == fault_record_pkg::TEMP1_HI + 8'h1) begin
      hdr_byte = temps_q.temp1[7:0];
    end else if (i_rd_addr == fault_record_pkg::TEMP_DIE_HI) begin
      hdr_byte = temps_q.temp_die[15:8];
    end else if (i_rd_addr == fault_record_pkg::TEMP_DIE_HI + 8'h1) begin
      hdr_byte = temps_q.temp_die[7:0];
    end
  end

  // First field of a page is its top byte, so walk down from the MSB
  always_comb begin
    rd_byte = fault_record_pkg::BYTE_ZERO;
    if (hdr_sel) begin
      rd_byte = hdr_byte;
    end else if (i_rd_addr < fault_record_pkg::REC_LEN) begin
      rd_byte = page_flat[(fault_record_pkg::PAGE_BITS - 8) - 8 * int'(page_byte_pos) +: 8];
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_rd_ack <= 1'b0;
      o_rd_data <= fault_record_pkg::BYTE_ZERO;
      o_rd_len <= fault_record_pkg::REC_LEN_EMPTY;
    end else begin
      o_rd_ack <= i_rd_req;
      if (i_rd_req) begin
        o_rd_data <= rd_byte;
      end
      o_rd_len <= (state_d == fault_record_pkg::ST_FROZEN) ?
        fault_record_pkg::REC_LEN : fault_record_pkg::REC_LEN_EMPTY;
    end
  end

endmodule

// [test/fault_record_checker.sv]
// Port-level assertions for the fault log record formatter.
// Bound to the formatter; TICK_CYCLES is handed on from the design.
module fault_record_checker #(
  parameter int TICK_CYCLES = fault_record_pkg::TICK_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_conv_valid,
  input wire logic [4:0] i_conv_step,
  input wire logic i_peak_clear_command,
  input wire logic i_rd_req,
  input wire logic [7:0] i_rd_addr,
  input wire logic o_rd_ack,
  input wire logic [7:0] o_rd_data,
  input wire logic [7:0] o_rd_len,
  input wire logic o_frozen,
  input wire logic o_commit,
  input wire logic [15:0] o_peak_output_current,
  input wire logic [15:0] o_peak_input_voltage,
  input wire logic [47:0] o_shared_time_counter
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  logic [15:0] gap_q;
  logic seen_q;
  // Cycles since the time counter last moved
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || $changed(o_shared_time_counter)) begin
      gap_q <= 16'h0001;
      seen_q <= i_resetn;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end
  property p_len;
    o_rd_len == (o_frozen ? 8'h93 : 8'h00);
  endproperty
  a_len: assert property (p_len) else $error("read length wrong");
  property p_ack;
    1'b1 |=> o_rd_ack == $past(i_rd_req);
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");
  property p_unmapped;
    i_rd_req && i_rd_addr > 8'h92 |=> o_rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("byte past record not zero");
  property p_hold;
    o_frozen |=> o_frozen;
  endproperty
  a_hold: assert property (p_hold) else $error("frozen record released");
  property p_commit;
    o_commit |-> $rose(o_frozen);
  endproperty
  a_commit: assert property (p_commit) else $error("commit without freeze");
  property p_pass;
    $rose(o_frozen) |-> $past(i_conv_valid) && $past(i_conv_step) == 5'h19;
  endproperty
  a_pass: assert property (p_pass) else $error("freeze not at pass end");
  property p_single;
    o_commit |=> !o_commit [*8];
  endproperty
  a_single: assert property (p_single) else $error("commit repeated");
  property p_clear;
    i_peak_clear_command && !i_conv_valid |=> ##1 o_peak_output_current == 16'h0000 && o_peak_input_voltage == 16'h0000;
  endproperty
  a_clear: assert property (p_clear) else $error("peaks not cleared");
  property p_tick;
    $changed(o_shared_time_counter) && seen_q |->
      gap_q == TICK_CYCLES && o_shared_time_counter == $past(o_shared_time_counter) + 48'h1;
  endproperty
  a_tick: assert property (p_tick) else $error("time counter step wrong");
endmodule

bind fault_log_record_formatter fault_record_checker #(.TICK_CYCLES(TICK_CYCLES)) u_checker (
  .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_conv_valid(i_conv_valid), .i_conv_step(i_conv_step),
  .i_peak_clear_command(i_peak_clear_command), .i_rd_req(i_rd_req), .i_rd_addr(i_rd_addr),
  .o_rd_ack(o_rd_ack), .o_rd_data(o_rd_data), .o_rd_len(o_rd_len), .o_frozen(o_frozen), .o_commit(o_commit),
  .o_peak_output_current(o_peak_output_current), .o_peak_input_voltage(o_peak_input_voltage),
  .o_shared_time_counter(o_shared_time_counter)
);

// [test/record_host.sv]
// Management host model reading record bytes one request at a time.
// Assumes the formatter acks one cycle after each request pulse.
module record_host (
  input wire logic i_clk_sys,
  input wire logic i_rd_ack,
  input wire logic [7:0] i_rd_data,
  output logic o_rd_req,
  output logic [7:0] o_rd_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  int gap = 0;
  initial begin
    o_rd_req = 1'b0;
    o_rd_addr = 8'h5A;
  end
  // Idle address is inverted so a stale address is never reused
  task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output bit ok);
    ok = 1'b0;
    data = 8'h00;
    repeat (gap) @(negedge i_clk_sys);
    @(negedge i_clk_sys);
    o_rd_req = 1'b1;
    o_rd_addr = addr;
    // Request is taken at one edge; the ack stands until the next one
    for (int n = 0; n < 3 && !ok; n++) begin
      @(negedge i_clk_sys);
      if (n == 0) begin
        o_rd_req = 1'b0;
        o_rd_addr = ~addr;
      end
      if (i_rd_ack === 1'b1) begin
        ok = 1'b1;
        data = i_rd_data;
      end
    end
  endtask
endmodule

// [test/fault_log_record_formatter_tb_top.sv]
// Self-checking bench for the record formatter against a queue model.
// Assumes the checker is bound and record_host reads the record.
module fault_log_record_formatter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic i_conv_valid = 1'b0;
  logic [4:0] i_conv_step = 5'h00;
  fault_record_pkg::event_page_s i_conv_page = '0;
  fault_record_pkg::temps_s i_conv_temps = '0;
  logic i_fault = 1'b0;
  logic i_peak_clear_command = 1'b0;
  logic i_rd_req, o_rd_ack, o_frozen, o_commit;
  logic [7:0] i_rd_addr, o_rd_data, o_rd_len;
  logic [15:0] o_peak_output_current, o_peak_input_voltage;
  logic [47:0] o_shared_time_counter;
  int mismatches = 0;
  int compares = 0;
  int cyc = 0;
  localparam int TICK = 4;
  logic [31:0] lfsr_q = 32'h71046B7B;
  logic [159:0] pages[$];
  logic [15:0] pk_i = 16'h0000, pk_v = 16'h0000, rec_i = 16'h0000, rec_v = 16'h0000;
  logic [47:0] tm_rec = '0, t_rec = '0;
  bit pend = 0, frz = 0;

  always #20 i_clk_sys = ~i_clk_sys;

  // Edges since reset release, for the time counter model
  always @(posedge i_clk_sys) begin
    if (i_resetn) cyc++;
  end

  fault_log_record_formatter #(.TICK_CYCLES(TICK)) DUT (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_conv_valid(i_conv_valid), .i_conv_step(i_conv_step),
    .i_conv_page(i_conv_page), .i_conv_temps(i_conv_temps), .i_fault(i_fault),
    .i_peak_clear_command(i_peak_clear_command), .i_rd_req(i_rd_req), .i_rd_addr(i_rd_addr),
    .o_rd_ack(o_rd_ack), .o_rd_data(o_rd_data), .o_rd_len(o_rd_len), .o_frozen(o_frozen), .o_commit(o_commit),
    .o_peak_output_current(o_peak_output_current), .o_peak_input_voltage(o_peak_input_voltage),
    .o_shared_time_counter(o_shared_time_counter)
  );
  record_host host (.i_clk_sys(i_clk_sys), .i_rd_ack(o_rd_ack), .i_rd_data(o_rd_data),
    .o_rd_req(i_rd_req), .o_rd_addr(i_rd_addr));

  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction
  function automatic real lin_exp_val(logic [15:0] v);
    int e;
    int m;
    e = $signed(v[15:11]);
    m = $signed(v[10:0]);
    return m * (2.0 ** e);
  endfunction
  function automatic logic [7:0] exp_byte(int a);
    logic [31:0] pv;
    pv = {rec_i, rec_v};
    if (a >= 5 && a <= 10) return t_rec[8 * (a - 5) +: 8];
    if (a >= 17 && a <= 20) return pv[31 - 8 * (a - 17) -: 8];
    if (a >= 21 && a <= 26) return tm_rec[47 - 8 * (a - 21) -: 8];
    if (a >= 27 && a <= 146 && (a - 27) / 20 < pages.size()) return pages[(a - 27) / 20][159 - 8 * ((a - 27) % 20) -: 8];
    return 8'h00;
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic final_report();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rd(input int a);
    logic [7:0] d;
    bit ok;
    host.gap = rnd() % 3;
    host.read_byte(a[7:0], d, ok);
    if (!ok) begin
      mismatches++;
      final_report();
    end else chk(d, exp_byte(a), "record byte");
  endtask
  task automatic conv(input int st, input bit flt);
    logic [159:0] pg;
    logic [63:0] r;
    @(negedge i_clk_sys);
    pg = {rnd(), rnd(), rnd(), rnd(), rnd()};
    r = {rnd(), rnd()};
    // Freezing step keeps peaks unchanged so the held copy is unambiguous
    if (st == 25 && pend) pg[111:80] = '0;
    if (st == 0) i_conv_temps = r[47:0];
    i_conv_valid = 1'b1;
    i_conv_step = st[4:0];
    i_conv_page = pg;
    i_fault = flt;
    if (flt && !pend) t_rec = 48'(cyc / TICK);
    pend = pend | flt;
    if (lin_exp_val(pg[111:96]) > lin_exp_val(pk_i)) pk_i = pg[111:96];
    if (lin_exp_val(pg[95:80]) > lin_exp_val(pk_v)) pk_v = pg[95:80];
    if (!frz) {rec_i, rec_v} = {pk_i, pk_v};
    if (st == 25 && !frz) begin
      pages.push_front(pg);
      if (pages.size() > 6) void'(pages.pop_back());
      tm_rec = i_conv_temps;
      frz = pend;
    end
  endtask
  task automatic pass(input int fs);
    for (int st = 0; st < 26; st++) conv(st, st == fs);
    @(negedge i_clk_sys);
    i_conv_valid = 1'b0;
    i_fault = 1'b0;
    i_conv_page = ~i_conv_page;
  endtask

  initial begin
    repeat (12) @(negedge i_clk_sys);
    i_resetn = 1'b1;
    chk(o_rd_len, 48'h0, "empty length");
    rd(27);
    for (int n = 0; n < 8; n++) begin
      pass(-1);
      chk(o_commit, 48'h0, "no commit");
      chk(o_shared_time_counter, 48'((cyc - 1) / TICK), "time counter");
      if (n == 2) begin
        @(negedge i_clk_sys);
        i_peak_clear_command = 1'b1;
        {pk_i, pk_v, rec_i, rec_v} = '0;
        @(negedge i_clk_sys);
        i_peak_clear_command = 1'b0;
      end
      rd(27 + 20 * (n % 6));
      rd(17 + n);
      chk(o_peak_output_current, pk_i, "peak current");
      chk(o_peak_input_voltage, pk_v, "peak voltage");
    end
    pass(15);
    chk(o_frozen, 48'h1, "frozen");
    chk(o_commit, 48'h1, "commit pulse");
    chk(o_rd_len, 48'h93, "full length");
    pass(3);
    for (int a = 0; a < 150; a++) rd(a);
    rd(200);
    final_report();
  end

  initial begin
    repeat (30000) @(posedge i_clk_sys);
    mismatches++;
    final_report();
  end
endmodule
